/* dv/cnmwc_bench.sv */
`timescale 1ns/1ps
`default_nettype none

module cnmwc_bench;
   import cnmwc_pkg::*;
   localparam int F = WAKE_FILTER_CYC;
   logic       clk = 1'b0;
   logic       rst_b = 1'b0;
   logic       mode_wr = 1'b0;
   logic [1:0] mode_sel = 2'h0;
   logic       flags_clr = 1'b0;
   logic       cfg_done = 1'b0;
   logic       sleep_wake_error_disable = 1'b0;
   logic       txd = 1'b1;
   logic       lwake = 1'b0;
   logic       vcc_uv = 1'b0;
   logic       vio_uv = 1'b0, thermal_shutdown_protected = 1'b0, tmode = 1'b0, wd_trig = 1'b0;
   logic [1:0] wd_act = 2'h0;
   logic       osc_en, wd_flag, wd_rst;
   logic       bus_dom;
   logic [4:0] o_mode;
   logic       drive, rxd, irq_n, wkrq_n, reg_en, spi_en, bw_flag, lw_flag, po_flag, uv_flag, fault, cfg_lost;
   int         error_cnt = 0;
   int         cmp_count = 0;
   int         seed = 13;
   logic [4:0] exp_q[$];
   logic [4:0] last_mode;

   cnmwc_top #(.P_WAKE_TIMEOUT_CYC(16'h00C8), .P_INACTIVE_CYC(33'h0_0000_07D0), .P_WD_CYC(21'h0_01F4)) cnmwc_top_i (
      .i_ref_clk(clk), .i_rst_b(rst_b), .i_mode_wr(mode_wr), .i_mode_sel(mode_sel), .i_flags_clr(flags_clr),
      .i_config_done(cfg_done), .i_sleep_wake_error_disable(sleep_wake_error_disable), .i_bus_dominant(bus_dom), .i_txd(txd),
      .i_local_wake_event(lwake), .i_vcc_uv(vcc_uv), .i_vio_uv(vio_uv), .i_tsd(thermal_shutdown_protected), .i_test_mode(tmode),
      .i_watchdog_action_select(wd_act), .i_watchdog_trigger_bit(wd_trig), .o_mode(o_mode),
      .o_bus_drive_dominant(drive), .o_rxd_int(rxd), .o_irq_out_n(irq_n), .o_wake_request_out_n(wkrq_n),
      .o_regulator_enable_out(reg_en), .o_spi_enable(spi_en), .o_osc_enable(osc_en), .o_bus_wake_flag(bw_flag),
      .o_local_wake_flag(lw_flag), .o_power_on_flag(po_flag), .o_uv_flag(uv_flag), .o_sleep_by_fault(fault),
      .o_watchdog_flag(wd_flag), .o_watchdog_reset_out(wd_rst), .o_config_lost(cfg_lost));
   cnmwc_bus_model cnmwc_bus_model_i (.i_ref_clk(clk), .o_bus_dominant(bus_dom));

   always #20 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [4:0] seen, input logic [4:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   task automatic pulse(ref logic s);
      s = 1'b1;
      @(negedge clk);
      s = 1'b0;
   endtask

   // host mode write, then let the one-edge output lag settle
   task automatic set_mode(input logic [1:0] sel);
      mode_sel = sel;
      pulse(mode_wr);
      repeat (3) @(negedge clk);
   endtask

   task automatic bph(input logic dom, input int n);
      cnmwc_bus_model_i.phase(dom, n);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // every mode change must match the oldest note; reset changes are skipped
   always @(negedge clk) begin
      if (rst_b && o_mode !== last_mode) begin
         if (exp_q.size() == 0) check("mode", o_mode, last_mode);
         else check("mode", o_mode, exp_q.pop_front());
      end
      last_mode = o_mode;
   end

   // hang guard, far beyond the roughly 6100 cycles of the sequence
   initial begin
      repeat (20000) @(negedge clk);
      error_cnt++;
      stop_test();
   end

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      int n;
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      check("power_on", 5'(po_flag), 5'h01);
      check("irq_n", 5'(irq_n), 5'h00);
      check("wkrq_n", 5'(wkrq_n), 5'h00);
      // normal mode with random transmit and bus levels
      exp_q.push_back(5'h04);
      set_mode(MODE_SEL_NORMAL);
      repeat (8) begin
         txd = 1'($random(seed));
         bph(1'($random(seed)), 1);
         check("drive", 5'(drive), 5'(!txd));
         check("rxd", 5'(rxd), 5'(!bus_dom));
      end
      bph(1'b0, 1);
      // host sleep command; no supply dip is driven around it
      exp_q.push_back(5'h01);
      set_mode(MODE_SEL_SLEEP);
      check("regulator", 5'(reg_en), 5'h00);
      check("spi", 5'(spi_en), 5'h00);
      check("cfg_lost", 5'(cfg_lost), 5'h01);
      set_mode(MODE_SEL_NORMAL);
      set_mode(MODE_SEL_STANDBY);
      check("mode", o_mode, 5'h01);
      // bus noise shorter than the filter never counts
      repeat (12) begin
         n = 1 + (($random(seed) & 32'h7FFF_FFFF) % (F - 1));
         bph(1'b1, n);
         bph(1'b0, n);
      end
      check("mode", o_mode, 5'h01);
      // pattern too slow: second dominant comes after the timeout
      bph(1'b1, F);
      bph(1'b0, 250);
      bph(1'b1, F);
      bph(1'b0, 250);
      check("mode", o_mode, 5'h01);
      exp_q.push_back(5'h02);
      bph(1'b1, F);
      bph(1'b0, F);
      bph(1'b1, F);
      bph(1'b0, 3);
      check("bus_wake", 5'(bw_flag), 5'h01);
      check("wkrq_n", 5'(wkrq_n), 5'h00);
      check("irq_n", 5'(irq_n), 5'h00);
      // request mode: receive low only for dominant time past the filter
      n = 0;
      fork
         begin
            bph(1'b1, F + 15);
            bph(1'b0, 10);
         end
         repeat (F + 25) begin
            @(negedge clk);
            if (rxd === 1'b0) n++;
         end
      join
      check("rxd_low", 5'(n), 5'h0F);
      pulse(lwake);
      repeat (3) @(negedge clk);
      check("local_flag", 5'(lw_flag), 5'h00);
      // inactivity expiry sends the node back to sleep
      exp_q.push_back(5'h01);
      n = 0;
      while (o_mode !== 5'h01 && n < 2500) begin
         @(negedge clk);
         n++;
      end
      check("early", 5'(n > 1800), 5'h01);
      check("mode", o_mode, 5'h01);
      check("fault", 5'(fault), 5'h01);
      // local wake with the timer disabled for sleep wakes
      sleep_wake_error_disable = 1'b1;
      exp_q.push_back(5'h02);
      pulse(lwake);
      repeat (2600) @(negedge clk);
      check("mode", o_mode, 5'h02);
      check("local_flag", 5'(lw_flag), 5'h01);
      set_mode(MODE_SEL_NORMAL);
      check("mode", o_mode, 5'h02);
      pulse(cfg_done);
      vcc_uv = 1'b1;
      repeat (3) @(negedge clk);
      vcc_uv = 1'b0;
      set_mode(MODE_SEL_NORMAL);
      check("mode", o_mode, 5'h02);
      pulse(flags_clr);
      check("uv_flag", 5'(uv_flag), 5'h01);
      exp_q.push_back(5'h04);
      set_mode(MODE_SEL_NORMAL);
      // test mode folds the reset pulse action into an interrupt
      tmode = 1'b1;
      wd_act = 2'h2;
      pulse(wd_trig);
      n = 0;
      repeat (520) begin
         @(negedge clk);
         if (wd_rst !== 1'b0) n++;
      end
      check("wd_rst", 5'(n), 5'h00);
      check("wd_flag", 5'(wd_flag), 5'h01);
      exp_q.push_back(5'h02);
      set_mode(MODE_SEL_STANDBY);
      // protected modes and the way back to standby
      exp_q.push_back(5'h08);
      thermal_shutdown_protected = 1'b1;
      repeat (3) @(negedge clk);
      exp_q.push_back(5'h10);
      vio_uv = 1'b1;
      repeat (3) @(negedge clk);
      check("osc", 5'(osc_en), 5'h00);
      check("irq_n", 5'(irq_n), 5'h01);
      thermal_shutdown_protected = 1'b0;
      exp_q.push_back(5'h02);
      vio_uv = 1'b0;
      repeat (3) @(negedge clk);
      check("spi", 5'(spi_en), 5'h01);
      // reset in mid-run returns to standby with defaults
      rst_b = 1'b0;
      repeat (2) @(negedge clk);
      rst_b = 1'b1;
      repeat (3) @(negedge clk);
      check("mode", o_mode, 5'h02);
      check("power_on", 5'(po_flag), 5'h01);
      stop_test();
   end
endmodule
`default_nettype wire

/* dv/cnmwc_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cnmwc_bus_model (
   input  wire logic i_ref_clk,
   output var logic  o_bus_dominant
);
   // bus weakly pulled to ground when nobody drives: reads recessive
   initial o_bus_dominant = 1'b0;

   // hold one bus level for n cycles; call on a falling edge only
   task automatic phase(input logic dom, input int n);
      o_bus_dominant = dom;
      repeat (n) @(negedge i_ref_clk);
   endtask
endmodule
`default_nettype wire

/* dv/cnmwc_checker.sv */
`timescale 1ns/1ps
`default_nettype none

module cnmwc_checker (
   input wire logic       i_ref_clk,
   input wire logic       i_rst_b,
   input wire logic       i_mode_wr,
   input wire logic [1:0] i_mode_sel,
   input wire logic       i_txd,
   input wire logic       i_bus_dominant,
   input wire logic       i_local_wake_event,
   input wire logic [4:0] o_mode,
   input wire logic       o_bus_drive_dominant,
   input wire logic       o_rxd_int,
   input wire logic       o_irq_out_n,
   input wire logic       o_wake_request_out_n,
   input wire logic       o_regulator_enable_out,
   input wire logic       o_spi_enable,
   input wire logic       o_sleep_by_fault
);
   logic [1:0] age;
   logic       ready;

   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rst_b);

   ////////////////////////////////////////////////////////////////////////////
   // outputs trail state by an edge, so skip the edges right after reset
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         age <= 2'h0;
      end else if (age != 2'h3) begin
         age <= age + 2'h1;
      end
   end
   assign ready = (age == 2'h3);

   ////////////////////////////////////////////////////////////////////////////
   // mode output relations
   property p_standby_out;
      ready && o_mode == 5'h02 && $past(o_mode) == 5'h02 |->
         o_regulator_enable_out && o_spi_enable && !o_wake_request_out_n && !o_bus_drive_dominant;
   endproperty
   a_standby_out: assert property (p_standby_out) else $error("standby outputs wrong");
   property p_sleep_out;
      ready && o_mode == 5'h01 |-> !o_regulator_enable_out && !o_spi_enable && o_irq_out_n;
   endproperty
   a_sleep_out: assert property (p_sleep_out) else $error("sleep outputs wrong");
   property p_drive_normal;
      o_bus_drive_dominant |-> o_mode == 5'h04;
   endproperty
   a_drive_normal: assert property (p_drive_normal) else $error("bus driven outside normal");
   property p_drive_follow;
      ready && o_mode == 5'h04 && $past(o_mode) == 5'h04 |-> o_bus_drive_dominant == !$past(i_txd);
   endproperty
   a_drive_follow: assert property (p_drive_follow) else $error("drive not following transmit");
   property p_rxd_follow;
      ready && o_mode == 5'h04 && $past(o_mode) == 5'h04 |-> o_rxd_int == !$past(i_bus_dominant);
   endproperty
   a_rxd_follow: assert property (p_rxd_follow) else $error("receive not following bus");
   property p_no_host_exit;
      (!i_bus_dominant && !i_local_wake_event) ##1
         (o_mode == 5'h01 && i_mode_wr && !i_bus_dominant && !i_local_wake_event) |-> ##2 o_mode == 5'h01;
   endproperty
   a_no_host_exit: assert property (p_no_host_exit) else $error("sleep left without wake");
   property p_leave_sleep;
      ready && $past(o_mode) == 5'h01 && o_mode != 5'h01 |-> o_mode == 5'h02;
   endproperty
   a_leave_sleep: assert property (p_leave_sleep) else $error("sleep exit not to standby");
   property p_wake_out;
      ready && $past(o_mode) == 5'h01 && o_mode == 5'h02 |-> !o_wake_request_out_n && !o_irq_out_n;
   endproperty
   a_wake_out: assert property (p_wake_out) else $error("wake not signalled");
   property p_normal_grant;
      ready && o_mode == 5'h04 && $past(o_mode) != 5'h04 |-> $past(i_mode_wr, 2) && $past(i_mode_sel, 2) == 2'h2;
   endproperty
   a_normal_grant: assert property (p_normal_grant) else $error("normal without host select");
   property p_fault_sleep;
      ready && $rose(o_sleep_by_fault) |-> o_mode == 5'h01;
   endproperty
   a_fault_sleep: assert property (p_fault_sleep) else $error("fault flag outside sleep");
endmodule

bind cnmwc_top cnmwc_checker cnmwc_checker_i (
   .i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_mode_wr(i_mode_wr), .i_mode_sel(i_mode_sel),
   .i_txd(i_txd), .i_bus_dominant(i_bus_dominant), .i_local_wake_event(i_local_wake_event),
   .o_mode(o_mode), .o_bus_drive_dominant(o_bus_drive_dominant), .o_rxd_int(o_rxd_int),
   .o_irq_out_n(o_irq_out_n), .o_wake_request_out_n(o_wake_request_out_n),
   .o_regulator_enable_out(o_regulator_enable_out), .o_spi_enable(o_spi_enable),
   .o_sleep_by_fault(o_sleep_by_fault)
);
`default_nettype wire

/* rtl/cnmwc_pkg.sv */
package cnmwc_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // clock and timing
   localparam longint CLK_HZ          = 25_000_000;
   localparam int     CLK_MHZ         = int'(CLK_HZ / 1_000_000);
   localparam int     WAKE_FILTER_NS  = 1000;
   localparam int     WAKE_TIMEOUT_US = 1000;
   localparam longint INACTIVE_S      = 240;
   localparam int     WD_TIMEOUT_MS   = 60;
   // least time rounds up, longest rounds down
   localparam int     WAKE_FILTER_CYC  = (WAKE_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam int     WAKE_TIMEOUT_CYC = WAKE_TIMEOUT_US * CLK_MHZ;
   localparam longint INACTIVE_CYC     = INACTIVE_S * CLK_HZ;
   localparam int     WD_CYC           = WD_TIMEOUT_MS * CLK_MHZ * 1000;

   ////////////////////////////////////////////////////////////////////////////
   // counter widths and terminal values
   localparam int             FLT_W     = 8;
   localparam int             WKTO_W    = 16;
   localparam int             INACT_W   = 33;
   localparam int             WD_W      = 21;
   localparam logic [FLT_W-1:0] FLT_TERM = FLT_W'(WAKE_FILTER_CYC);

   ////////////////////////////////////////////////////////////////////////////
   // host mode selection and watchdog action codes
   localparam logic [1:0] MODE_SEL_SLEEP   = 2'h0;
   localparam logic [1:0] MODE_SEL_STANDBY = 2'h1;
   localparam logic [1:0] MODE_SEL_NORMAL  = 2'h2;
   localparam logic [1:0] WD_ACT_IRQ       = 2'h0;
   localparam logic [1:0] WD_ACT_STANDBY   = 2'h1;
   localparam logic [1:0] WD_ACT_RST_PIN   = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // state encodings
   typedef enum logic [4:0] {
      CNMWC_SLEEP   = 5'h01,
      CNMWC_STANDBY = 5'h02,
      CNMWC_NORMAL  = 5'h04,
      CNMWC_TSD     = 5'h08,
      CNMWC_IO_UNDERVOLTAGE_PROTECTED    = 5'h10
   } cnmwc_mode_t;

   typedef enum logic [4:0] {
      WK_IDLE     = 5'h01,
      WK_DOM1     = 5'h02,
      WK_REC      = 5'h04,
      WK_BUS_WAKE_REQUEST     = 5'h08,
      WK_WAIT_REC = 5'h10
   } cnmwc_wake_t;

endpackage

/* rtl/cnmwc_top.sv */
`timescale 1ns/1ps
`default_nettype none

module cnmwc_top
   import cnmwc_pkg::*;
#(
   parameter logic [WKTO_W-1:0]  P_WAKE_TIMEOUT_CYC = WKTO_W'(WAKE_TIMEOUT_CYC),
   parameter logic [INACT_W-1:0] P_INACTIVE_CYC     = INACT_W'(INACTIVE_CYC),
   parameter logic [WD_W-1:0]    P_WD_CYC           = WD_W'(WD_CYC)
) (
   input  wire logic       i_ref_clk,
   input  wire logic       i_rst_b,
   input  wire logic       i_mode_wr,
   input  wire logic [1:0] i_mode_sel,
   input  wire logic       i_flags_clr,
   input  wire logic       i_config_done,
   input  wire logic       i_sleep_wake_error_disable,
   input  wire logic       i_bus_dominant,
   input  wire logic       i_txd,
   input  wire logic       i_local_wake_event,
   input  wire logic       i_vcc_uv,
   input  wire logic       i_vio_uv,
   input  wire logic       i_tsd,
   input  wire logic       i_test_mode,
   input  wire logic [1:0] i_watchdog_action_select,
   input  wire logic       i_watchdog_trigger_bit,
   output logic [4:0]      o_mode,
   output logic            o_bus_drive_dominant,
   output logic            o_rxd_int,
   output logic            o_irq_out_n,
   output logic            o_wake_request_out_n,
   output logic            o_regulator_enable_out,
   output logic            o_spi_enable,
   output logic            o_osc_enable,
   output logic            o_bus_wake_flag,
   output logic            o_local_wake_flag,
   output logic            o_power_on_flag,
   output logic            o_uv_flag,
   output logic            o_sleep_by_fault,
   output logic            o_watchdog_flag,
   output logic            o_watchdog_reset_out,
   output logic            o_config_lost
);

   ////////////////////////////////////////////////////////////////////////////
   // wake pattern detector state
   cnmwc_wake_t       wk_state, next_wk_state;
   logic [FLT_W-1:0]  run_cnt, next_run_cnt;
   logic              last_dom, next_last_dom;
   logic [WKTO_W-1:0] to_cnt, next_to_cnt;
   logic              filt_hit, filt_dom, filt_rec, det_en, wake_bus_evt;

   ////////////////////////////////////////////////////////////////////////////
   // mode controller state
   cnmwc_mode_t        mode, next_mode;
   logic               bw_flag, next_bw_flag;
   logic               lw_flag, next_lw_flag;
   logic               pwron_flag, next_pwron_flag;
   logic               uv_latched, next_uv_latched;
   logic               sleep_fault, next_sleep_fault;
   logic               wake_given, next_wake_given;
   logic               cfg_lost, next_cfg_lost;
   logic               inact_run, next_inact_run;
   logic [INACT_W-1:0] inact_cnt, next_inact_cnt;
   logic               wd_run, next_wd_run;
   logic [WD_W-1:0]    wd_cnt, next_wd_cnt;
   logic               wd_flag, next_wd_flag;
   logic               wd_rst_pulse, next_wd_rst_pulse;
   logic               spi_on, flags_clr, mode_ok, set_bw, set_lw, wd_fire;
   logic [1:0]         wd_act;

   ////////////////////////////////////////////////////////////////////////////
   // wake detector next state
   always_comb begin
      next_last_dom = i_bus_dominant;
      // run length of the current bus level, first cycle counts as one, saturating
      if (i_bus_dominant != last_dom) begin
         next_run_cnt = FLT_W'(1);
      end else if (run_cnt == FLT_TERM) begin
         next_run_cnt = run_cnt;
      end else begin
         next_run_cnt = run_cnt + FLT_W'(1);
      end
      // level held a full filter time; shorter levels never qualify
      filt_hit = (i_bus_dominant == last_dom) && (run_cnt == FLT_TERM - FLT_W'(1));
      filt_dom = filt_hit && i_bus_dominant;
      filt_rec = filt_hit && !i_bus_dominant;
      det_en = (mode != CNMWC_NORMAL); // low power receiver off in normal
      next_wk_state = wk_state;
      next_to_cnt = to_cnt;
      wake_bus_evt = 1'b0;
      case (wk_state)
         WK_IDLE: begin
            if (filt_dom) begin // first filtered dominant
               next_wk_state = WK_DOM1;
               next_to_cnt = '0;
            end
         end
         WK_DOM1, WK_REC: begin
            next_to_cnt = to_cnt + WKTO_W'(1);
            if (to_cnt == P_WAKE_TIMEOUT_CYC - WKTO_W'(1)) begin
               next_wk_state = WK_WAIT_REC; // pattern too slow
            end else if (wk_state == WK_DOM1 && filt_rec) begin
               next_wk_state = WK_REC; // short glitches ignored meanwhile
            end else if (wk_state == WK_REC && filt_dom) begin
               next_wk_state = WK_BUS_WAKE_REQUEST; // advance immediately
               wake_bus_evt = 1'b1;
            end
         end
         WK_BUS_WAKE_REQUEST: begin
            wake_bus_evt = filt_dom; // every later filtered dominant
         end
         WK_WAIT_REC: begin
            if (!i_bus_dominant) begin
               next_wk_state = WK_IDLE; // fresh pattern needed
            end
         end
         default: begin
            next_wk_state = WK_IDLE;
         end
      endcase
      // request dropped on normal or transceiver undervoltage
      if (!det_en || i_vcc_uv) begin
         next_wk_state = WK_IDLE;
         wake_bus_evt = 1'b0;
      end
   end

   // wake detector registers
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         wk_state <= WK_IDLE;
         run_cnt  <= '0;
         last_dom <= 1'b0;
         to_cnt   <= '0;
      end else begin
         wk_state <= next_wk_state;
         run_cnt  <= next_run_cnt;
         last_dom <= next_last_dom;
         to_cnt   <= next_to_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mode controller next state
   always_comb begin
      next_mode = mode;
      next_bw_flag = bw_flag;
      next_lw_flag = lw_flag;
      next_pwron_flag = pwron_flag;
      next_uv_latched = uv_latched;
      next_sleep_fault = sleep_fault;
      next_wake_given = wake_given;
      next_cfg_lost = cfg_lost;
      next_inact_run = inact_run;
      next_inact_cnt = inact_cnt;
      next_wd_run = wd_run;
      next_wd_cnt = wd_cnt;
      next_wd_flag = wd_flag;
      next_wd_rst_pulse = 1'b0;
      wd_fire = 1'b0;
      // spi dead in sleep and io undervoltage, so writes vanish there
      spi_on = (mode != CNMWC_SLEEP) && (mode != CNMWC_IO_UNDERVOLTAGE_PROTECTED);
      flags_clr = i_flags_clr && spi_on;
      mode_ok = i_mode_wr && spi_on;
      // first wake only while in standby; any wake counts in sleep
      set_bw = wake_bus_evt && (mode == CNMWC_SLEEP || (mode == CNMWC_STANDBY && !wake_given));
      set_lw = i_local_wake_event && (mode != CNMWC_NORMAL) &&
               (mode != CNMWC_STANDBY || !wake_given);
      // in test mode only irq and standby actions exist
      wd_act = (i_test_mode && i_watchdog_action_select[1]) ? WD_ACT_IRQ : i_watchdog_action_select;
      // sticky flags: a set in the clear cycle wins
      if (set_bw) next_bw_flag = 1'b1;
      else if (flags_clr) next_bw_flag = 1'b0;
      if (set_lw) next_lw_flag = 1'b1;
      else if (flags_clr) next_lw_flag = 1'b0;
      if (set_bw || set_lw) next_wake_given = 1'b1;
      if (flags_clr) next_pwron_flag = 1'b0;
      if (i_vcc_uv || i_vio_uv) next_uv_latched = 1'b1;
      else if (flags_clr) next_uv_latched = 1'b0;
      if (i_config_done && spi_on) next_cfg_lost = 1'b0;
      // inactivity timer stops once host clears flags or goes normal
      if (inact_run) next_inact_cnt = inact_cnt + INACT_W'(1);
      if (flags_clr) next_inact_run = 1'b0;
      // watchdog restarted by trigger bit and on each timeout; held in reset in io uv
      if (i_watchdog_trigger_bit && spi_on) begin
         next_wd_run = 1'b1;
         next_wd_cnt = '0;
      end else if (wd_run && mode != CNMWC_IO_UNDERVOLTAGE_PROTECTED) begin
         next_wd_cnt = wd_cnt + WD_W'(1);
         if (wd_cnt == P_WD_CYC - WD_W'(1)) begin
            next_wd_cnt = '0;
            next_wd_flag = 1'b1;
            next_wd_rst_pulse = (wd_act == WD_ACT_RST_PIN);
            wd_fire = 1'b1;
         end
      end else if (mode == CNMWC_IO_UNDERVOLTAGE_PROTECTED) begin
         next_wd_cnt = '0;
      end
      if (flags_clr && !wd_fire) next_wd_flag = 1'b0; // a timeout in the clear cycle wins
      case (mode)
         CNMWC_SLEEP: begin
            // only a wake leaves sleep; mode writes ignored
            if (set_bw || set_lw) begin
               next_mode = CNMWC_STANDBY;
               next_inact_run = !i_sleep_wake_error_disable;
               next_inact_cnt = '0;
            end
         end
         CNMWC_STANDBY, CNMWC_NORMAL: begin
            if (i_vio_uv) begin
               next_mode = CNMWC_IO_UNDERVOLTAGE_PROTECTED;
            end else if (i_tsd) begin
               next_mode = CNMWC_TSD;
            end else if (mode == CNMWC_STANDBY && inact_run &&
                         inact_cnt == P_INACTIVE_CYC - INACT_W'(1)) begin
               next_mode = CNMWC_SLEEP; // timer expiry
               next_sleep_fault = 1'b1;
            end else if (wd_flag == 1'b0 && next_wd_flag && wd_act == WD_ACT_STANDBY) begin
               next_mode = CNMWC_STANDBY;
               next_wake_given = (mode == CNMWC_STANDBY) ? wake_given : 1'b0;
            end else if (mode_ok) begin // only host selects modes
               if (i_mode_sel == MODE_SEL_SLEEP) begin
                  next_mode = CNMWC_SLEEP;
                  next_sleep_fault = 1'b0;
               end else if (i_mode_sel == MODE_SEL_NORMAL && !next_uv_latched && !cfg_lost) begin
                  next_mode = CNMWC_NORMAL; // refused after uv or lost config
                  next_inact_run = 1'b0;
               end else if (i_mode_sel == MODE_SEL_STANDBY && mode == CNMWC_NORMAL) begin
                  next_mode = CNMWC_STANDBY;
                  next_wake_given = 1'b0; // re-arm first wake interrupt
               end
            end
         end
         CNMWC_TSD: begin
            if (i_vio_uv) next_mode = CNMWC_IO_UNDERVOLTAGE_PROTECTED;
            else if (!i_tsd) next_mode = CNMWC_STANDBY;
         end
         CNMWC_IO_UNDERVOLTAGE_PROTECTED: begin
            if (!i_vio_uv) next_mode = CNMWC_STANDBY;
         end
         default: begin
            next_mode = CNMWC_STANDBY;
         end
      endcase
      // entering sleep powers down registers, keeping only the cause flag and the uv flag
      if (next_mode == CNMWC_SLEEP && mode != CNMWC_SLEEP) begin
         next_bw_flag = 1'b0;
         next_lw_flag = 1'b0;
         next_pwron_flag = 1'b0;
         next_wd_flag = 1'b0;
         next_cfg_lost = 1'b1;
         next_inact_run = 1'b0;
         next_wd_run = 1'b0;
         next_wake_given = 1'b0;
      end
   end

   // mode registers; reset enters standby with timer running
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         mode         <= CNMWC_STANDBY;
         bw_flag      <= 1'b0;
         lw_flag      <= 1'b0;
         pwron_flag   <= 1'b1;
         uv_latched   <= 1'b0;
         sleep_fault  <= 1'b0;
         wake_given   <= 1'b0;
         cfg_lost     <= 1'b0;
         inact_run    <= 1'b1;
         inact_cnt    <= '0;
         wd_run       <= 1'b0;
         wd_cnt       <= '0;
         wd_flag      <= 1'b0;
         wd_rst_pulse <= 1'b0;
      end else begin
         mode         <= next_mode;
         bw_flag      <= next_bw_flag;
         lw_flag      <= next_lw_flag;
         pwron_flag   <= next_pwron_flag;
         uv_latched   <= next_uv_latched;
         sleep_fault  <= next_sleep_fault;
         wake_given   <= next_wake_given;
         cfg_lost     <= next_cfg_lost;
         inact_run    <= next_inact_run;
         inact_cnt    <= next_inact_cnt;
         wd_run       <= next_wd_run;
         wd_cnt       <= next_wd_cnt;
         wd_flag      <= next_wd_flag;
         wd_rst_pulse <= next_wd_rst_pulse;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // output flops: one cycle behind state, traded for glitch-free pins
   always_ff @(posedge i_ref_clk) begin
      if (!i_rst_b) begin
         o_mode                 <= CNMWC_STANDBY;
         o_bus_drive_dominant   <= 1'b0;
         o_rxd_int              <= 1'b1;
         o_irq_out_n            <= 1'b1;
         o_wake_request_out_n   <= 1'b1;
         o_regulator_enable_out <= 1'b1;
         o_spi_enable           <= 1'b1;
         o_osc_enable           <= 1'b1;
         o_bus_wake_flag        <= 1'b0;
         o_local_wake_flag      <= 1'b0;
         o_power_on_flag        <= 1'b0;
         o_uv_flag              <= 1'b0;
         o_sleep_by_fault       <= 1'b0;
         o_watchdog_flag        <= 1'b0;
         o_watchdog_reset_out   <= 1'b0;
         o_config_lost          <= 1'b0;
      end else begin
         o_mode                 <= mode;
         o_bus_drive_dominant   <= (mode == CNMWC_NORMAL) && !i_txd;
         // normal: bus state; else low only for dominant past filter
         o_rxd_int              <= (mode == CNMWC_NORMAL) ? !i_bus_dominant :
                                   !(wk_state == WK_BUS_WAKE_REQUEST && i_bus_dominant && run_cnt == FLT_TERM);
         o_irq_out_n            <= !(spi_on && (bw_flag || lw_flag || pwron_flag || uv_latched ||
                                                 sleep_fault || wd_flag));
         o_wake_request_out_n   <= (mode == CNMWC_SLEEP); // alive in sleep
         o_regulator_enable_out <= spi_on;
         o_spi_enable           <= spi_on;
         o_osc_enable           <= (mode != CNMWC_IO_UNDERVOLTAGE_PROTECTED);
         o_bus_wake_flag        <= bw_flag;
         o_local_wake_flag      <= lw_flag;
         o_power_on_flag        <= pwron_flag;
         o_uv_flag              <= uv_latched;
         o_sleep_by_fault       <= sleep_fault;
         o_watchdog_flag        <= wd_flag;
         o_watchdog_reset_out   <= wd_rst_pulse;
         o_config_lost          <= cfg_lost;
      end
   end

endmodule

`default_nettype wire
